// [shared/rbg_map.vh]
// Register offsets, field positions and reset values of the backup bus gate and alarm block
// Notes on behaviour
// - While the main supply is under the reset threshold the serial bus is disabled, whatever the mode bits say.
// - Mode A (both select bits 0) uses standard switchover at the trip threshold, denies bus and EEPROM in backup, and keeps the interrupt output alive.
// - In mode A the bus works down to the reset threshold and is off every time the part enters battery backup.
// - Mode B (bus-in-backup 0, switchover 1) switches at supply below battery and allows bus and EEPROM in backup only while battery and supply are both above the reset threshold.
// - Mode C (bus-in-backup 1, switchover 0) behaves exactly like mode A.
// - Mode D (both bits 1) switches at supply below battery and allows the bus only while supply is above both the reset threshold and the battery.
// - The interrupt/frequency output stays driven during battery backup in all four modes.
// - After reset the standard backup mode is selected until software changes the mode bits.
// - Each of the six alarm-0 registers holds an enable in bit 7 and a BCD compare value in the low bits.
// - An alarm register with its enable clear is left out of the match.
// - With the repeat select bit 0 the alarm fires once, when every enabled field equals the current time.
`ifndef RBG_MAP_VH
`define RBG_MAP_VH
`define RBG_OFF_ALM_SEC   12'h000
`define RBG_OFF_ALM_MIN   12'h004
`define RBG_OFF_ALM_HR    12'h008
`define RBG_OFF_ALM_DATE  12'h00c
`define RBG_OFF_ALM_MON   12'h010
`define RBG_OFF_ALM_WDAY  12'h014
`define RBG_OFF_CTRL      12'h018
`define RBG_OFF_STATUS    12'h01c
`define RBG_OFF_MASK      12'h020
`define RBG_OFF_TIME0     12'h024
`define RBG_OFF_TIME1     12'h028
`define RBG_ALM_EN_BIT    7
`define RBG_CTRL_SWSEL    0
`define RBG_CTRL_BIBSEL   1
`define RBG_CTRL_REPEAT   2
`define RBG_CTRL_ARM      3
`define RBG_ST_ALARM      0
`define RBG_ST_BUSLOSS    1
`define RBG_ALM_RESET     8'h00
`define RBG_CTRL_RESET    4'h0
`define RBG_MASK_RESET    2'h0
`endif

// [hdl/rbg_backup_gate.v]
// Backup bus gate, alarm 0 compare and APB register file
//
// Chosen here: the APB slave port and the address map.
`include "rbg_map.vh"
module rbg_backup_gate (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Supply comparators
  input  wire        vddAboveReset,
  input  wire        vddAboveTrip,
  input  wire        vddAboveBat,
  input  wire        batAboveReset,
  // Timekeeping inputs
  input  wire        secondTick,
  input  wire [7:0]  timeSeconds,
  input  wire [7:0]  timeMinutes,
  input  wire [7:0]  timeHours,
  input  wire [7:0]  timeDate,
  input  wire [7:0]  timeMonth,
  input  wire [7:0]  timeWeekday,
  // Outputs
  output reg         busEnable,
  output reg         eepromEnable,
  output reg         batteryBackup,
  output reg         freqOutEnable,
  output reg         alarmPulse,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] alarm0_seconds;
  reg [7:0] alarm0_minutes;
  reg [7:0] alarm0_hours;
  reg [7:0] alarm0_date;
  reg [7:0] alarm0_month;
  reg [7:0] alarm0_weekday;
  reg       switchover_select;
  reg       bus_in_backup_select;
  reg       interrupt_repeat_select;
  reg       alarmArmed;
  reg [1:0] mask;

  wire       setupWr = psel & ~penable & pwrite;
  wire       accWr   = psel & penable & pwrite & pready;
  wire       accRd   = psel & penable & ~pwrite & pready;
  wire [1:0] modeSel = {bus_in_backup_select, switchover_select};
  wire [1:0] status;

  // ----------------------------------------------------------------
  // Power path and bus gate
  // ----------------------------------------------------------------
  reg next_backup;
  reg next_bus;
  reg next_eeprom;
  always @* begin
    next_backup = 1'b0;
    next_bus    = 1'b0;
    next_eeprom = 1'b0;
    case (modeSel)
      2'b00, 2'b10: begin
        // Supply passes the reset level before trip, so backup always finds the bus off
        next_backup = ~vddAboveTrip;
        next_bus    = vddAboveReset & ~next_backup;
        next_eeprom = next_bus;
      end
      2'b01: begin
        // Battery switchover; the bus may stay up in backup while the battery is above reset
        next_backup = ~vddAboveBat;
        next_bus    = vddAboveReset & (~next_backup | batAboveReset);
        next_eeprom = next_bus;
      end
      2'b11: begin
        // The bus needs a supply above both the reset level and the battery
        next_backup = ~vddAboveBat;
        next_bus    = vddAboveReset & vddAboveBat;
        next_eeprom = next_bus;
      end
      default: begin
        next_backup = 1'b0;
        next_bus    = 1'b0;
        next_eeprom = 1'b0;
      end
    endcase
    if (!vddAboveReset) begin
      next_bus    = 1'b0;
      next_eeprom = 1'b0;
    end
  end

  // Registered so a comparator edge never reaches the gate outputs as a glitch
  always @(posedge clk) begin
    if (!resetn) begin
      busEnable     <= 1'b0;
      eepromEnable  <= 1'b0;
      batteryBackup <= 1'b0;
      freqOutEnable <= 1'b1;
    end else begin
      busEnable     <= next_bus;
      eepromEnable  <= next_eeprom;
      batteryBackup <= next_backup;
      freqOutEnable <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Alarm 0 compare
  // ----------------------------------------------------------------
  wire [5:0] fieldEn;
  wire [5:0] fieldHit;

  rbg_field_cmp rbg_field_cmp_sec_inst (
    .alarmField   (alarm0_seconds),
    .timeField    (timeSeconds),
    .fieldEnabled (fieldEn[0]),
    .fieldOk      (fieldHit[0])
  );

  rbg_field_cmp rbg_field_cmp_min_inst (
    .alarmField   (alarm0_minutes),
    .timeField    (timeMinutes),
    .fieldEnabled (fieldEn[1]),
    .fieldOk      (fieldHit[1])
  );

  rbg_field_cmp rbg_field_cmp_hr_inst (
    .alarmField   (alarm0_hours),
    .timeField    (timeHours),
    .fieldEnabled (fieldEn[2]),
    .fieldOk      (fieldHit[2])
  );

  rbg_field_cmp rbg_field_cmp_date_inst (
    .alarmField   (alarm0_date),
    .timeField    (timeDate),
    .fieldEnabled (fieldEn[3]),
    .fieldOk      (fieldHit[3])
  );

  rbg_field_cmp rbg_field_cmp_mon_inst (
    .alarmField   (alarm0_month),
    .timeField    (timeMonth),
    .fieldEnabled (fieldEn[4]),
    .fieldOk      (fieldHit[4])
  );

  rbg_field_cmp rbg_field_cmp_wday_inst (
    .alarmField   (alarm0_weekday),
    .timeField    (timeWeekday),
    .fieldEnabled (fieldEn[5]),
    .fieldOk      (fieldHit[5])
  );

  // ----------------------------------------------------------------
  // Match and fire
  // ----------------------------------------------------------------
  // With no field enabled the alarm would hit every second, so it stays quiet
  wire anyEnabled = |fieldEn;
  wire match      = anyEnabled & (&fieldHit);
  // Single mode disarms itself; repeat mode keeps firing
  wire       fire    = secondTick & match & alarmArmed;
  wire       busLoss = busEnable & ~next_bus;
  wire [1:0] evt     = {busLoss, fire};

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Anything past the last word or off a word boundary is answered with an error
  wire addrAligned = (paddr[1:0] == 2'b00);
  wire addrInRange = (paddr <= `RBG_OFF_TIME1);
  wire addrBad     = ~addrAligned | ~addrInRange;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status shows this edge's events too, since the clearing read would otherwise drop them
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `RBG_OFF_ALM_SEC:  next_rdata = {24'h000000, alarm0_seconds};
      `RBG_OFF_ALM_MIN:  next_rdata = {24'h000000, alarm0_minutes};
      `RBG_OFF_ALM_HR:   next_rdata = {24'h000000, alarm0_hours};
      `RBG_OFF_ALM_DATE: next_rdata = {24'h000000, alarm0_date};
      `RBG_OFF_ALM_MON:  next_rdata = {24'h000000, alarm0_month};
      `RBG_OFF_ALM_WDAY: next_rdata = {24'h000000, alarm0_weekday};
      `RBG_OFF_CTRL:     next_rdata = {28'h0000000, alarmArmed, interrupt_repeat_select,
                                       bus_in_backup_select, switchover_select};
      `RBG_OFF_STATUS:   next_rdata = {30'h0, status | evt};
      `RBG_OFF_MASK:     next_rdata = {30'h0, mask};
      `RBG_OFF_TIME0:    next_rdata = {timeHours, timeMinutes, timeSeconds, 8'h00};
      `RBG_OFF_TIME1:    next_rdata = {5'h0, batteryBackup, eepromEnable, busEnable,
                                       timeWeekday, timeMonth, timeDate};
      default:           next_rdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      alarm0_seconds          <= `RBG_ALM_RESET;
      alarm0_minutes          <= `RBG_ALM_RESET;
      alarm0_hours            <= `RBG_ALM_RESET;
      alarm0_date             <= `RBG_ALM_RESET;
      alarm0_month            <= `RBG_ALM_RESET;
      alarm0_weekday          <= `RBG_ALM_RESET;
      switchover_select       <= 1'b0;
      bus_in_backup_select    <= 1'b0;
      interrupt_repeat_select <= 1'b0;
      alarmArmed              <= 1'b0;
      mask                    <= `RBG_MASK_RESET;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      prdata                  <= 32'h00000000;
      alarmPulse              <= 1'b0;
    end else begin
      pready     <= setupWr | (psel & ~penable);
      alarmPulse <= fire;
      if (fire && !interrupt_repeat_select)
        alarmArmed <= 1'b0;
      // The error flag stands only for the access cycle after its setup
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        pslverr <= addrBad;
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
      end
      // A write lands only at the access edge, with ready high
      if (accWr) begin
        case (paddr)
          `RBG_OFF_ALM_SEC:  alarm0_seconds <= pwdata[7:0];
          `RBG_OFF_ALM_MIN:  alarm0_minutes <= pwdata[7:0];
          `RBG_OFF_ALM_HR:   alarm0_hours   <= pwdata[7:0];
          `RBG_OFF_ALM_DATE: alarm0_date    <= pwdata[7:0];
          `RBG_OFF_ALM_MON:  alarm0_month   <= pwdata[7:0];
          `RBG_OFF_ALM_WDAY: alarm0_weekday <= pwdata[7:0];
          `RBG_OFF_CTRL: begin
            switchover_select       <= pwdata[`RBG_CTRL_SWSEL];
            bus_in_backup_select    <= pwdata[`RBG_CTRL_BIBSEL];
            interrupt_repeat_select <= pwdata[`RBG_CTRL_REPEAT];
            alarmArmed              <= pwdata[`RBG_CTRL_ARM];
          end
          `RBG_OFF_MASK: mask <= pwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // A read clears status, but an event in the same cycle survives
  wire       rdStatus   = accRd & (paddr == `RBG_OFF_STATUS);
  wire [1:0] nextStatus = (rdStatus ? 2'b00 : status) | evt;

  rbg_sticky_flag rbg_sticky_flag_alarm_inst (
    .clk       (clk),
    .resetn    (resetn),
    .setEvent  (evt[`RBG_ST_ALARM]),
    .clearRead (rdStatus),
    .flag      (status[`RBG_ST_ALARM])
  );

  rbg_sticky_flag rbg_sticky_flag_busloss_inst (
    .clk       (clk),
    .resetn    (resetn),
    .setEvent  (evt[`RBG_ST_BUSLOSS]),
    .clearRead (rdStatus),
    .flag      (status[`RBG_ST_BUSLOSS])
  );

  // The level follows the status of this edge, so it drops together with the clearing read
  always @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nextStatus & mask);
    end
  end

endmodule

// ----------------------------------------------------------------
// One alarm field against the current time
// ----------------------------------------------------------------
module rbg_field_cmp #(
  parameter FIELD_W = 8
) (
  // Alarm register and current time
  input  wire [FIELD_W-1:0] alarmField,
  input  wire [FIELD_W-1:0] timeField,
  // Compare result
  output wire               fieldEnabled,
  output wire               fieldOk
);

  // The top bit enables the field; the BCD value below it is compared as stored
  assign fieldEnabled = alarmField[`RBG_ALM_EN_BIT];
  // A disabled field is left out of the match
  assign fieldOk      = ~alarmField[`RBG_ALM_EN_BIT] |
                        (alarmField[`RBG_ALM_EN_BIT-1:0] == timeField[`RBG_ALM_EN_BIT-1:0]);

endmodule

// ----------------------------------------------------------------
// Sticky status flag, cleared by a read
// ----------------------------------------------------------------
module rbg_sticky_flag (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  // Event and clearing read
  input  wire setEvent,
  input  wire clearRead,
  // Flag
  output reg  flag
);

  // Set wins over the clearing read so that no event is lost
  always @(posedge clk) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else begin
      flag <= (flag & ~clearRead) | setEvent;
    end
  end

endmodule

// [tb/rbg_supply_model.sv]
// Supply and battery comparator model for the backup gate
module rbg_supply_model #(
  parameter int TRIP = 2200,
  parameter int RST  = 2700
) (
  // Voltages in millivolts
  input  int   vdd,
  input  int   bat,
  // Comparator levels
  output logic vddAboveReset,
  output logic vddAboveTrip,
  output logic vddAboveBat,
  output logic batAboveReset
);
  timeunit 1ns;
  timeprecision 1ps;
  assign vddAboveReset = vdd > RST;
  assign vddAboveTrip  = vdd > TRIP;
  assign vddAboveBat   = vdd > bat;
  assign batAboveReset = bat > RST;
endmodule

// [tb/rbg_backup_gate_props.sv]
// Checker for the backup gate ports
module rbg_backup_gate_props (
  input wire logic clk, resetn, psel, penable, pready, pslverr,
  input wire logic vddAboveReset, vddAboveTrip, vddAboveBat,
  input wire logic secondTick, busEnable, batteryBackup, freqOutEnable, alarmPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_lvr; !vddAboveReset |=> !busEnable; endproperty
  a_lvr: assert property (p_lvr) else $error("bus on below reset");
  property p_fout; resetn |-> freqOutEnable; endproperty
  a_fout: assert property (p_fout) else $error("freq out off");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_rdyp; pready |=> !pready; endproperty
  a_rdyp: assert property (p_rdyp) else $error("ready held");
  property p_alm; alarmPulse |-> $past(secondTick); endproperty
  a_alm: assert property (p_alm) else $error("alarm off tick");
  property p_almp; alarmPulse |=> !alarmPulse; endproperty
  a_almp: assert property (p_almp) else $error("alarm held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error w/o ready");
  property p_bb; !vddAboveTrip && !vddAboveBat |=> batteryBackup; endproperty
  a_bb: assert property (p_bb) else $error("no backup");
  c_alm: cover property (alarmPulse);
  c_err: cover property (pslverr);
  c_bus: cover property (batteryBackup && busEnable);
endmodule
bind rbg_backup_gate rbg_backup_gate_props rbg_backup_gate_props_inst (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .vddAboveReset(vddAboveReset),
  .vddAboveTrip(vddAboveTrip), .vddAboveBat(vddAboveBat), .secondTick(secondTick),
  .busEnable(busEnable), .batteryBackup(batteryBackup), .freqOutEnable(freqOutEnable), .alarmPulse(alarmPulse));

// [tb/rbg_testbench.sv]
// Self-checking bench for the backup gate and alarm
`include "rbg_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, psel, penable, pwrite, secondTick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, vR, vT, vB, bR, busEnable, eepromEnable, batteryBackup, freqOutEnable, alarmPulse, irq;
  logic [7:0] timeSeconds, timeMinutes, timeHours, timeDate, timeMonth, timeWeekday;
  int vdd, bat, err_total, n_tests, cyc;
  rbg_supply_model rbg_supply_model_inst (.vdd(vdd), .bat(bat), .vddAboveReset(vR), .vddAboveTrip(vT),
    .vddAboveBat(vB), .batAboveReset(bR));
  rbg_backup_gate rbg_backup_gate_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vddAboveReset(vR), .vddAboveTrip(vT), .vddAboveBat(vB), .batAboveReset(bR), .secondTick(secondTick),
    .timeSeconds(timeSeconds), .timeMinutes(timeMinutes), .timeHours(timeHours), .timeDate(timeDate),
    .timeMonth(timeMonth), .timeWeekday(timeWeekday), .busEnable(busEnable), .eepromEnable(eepromEnable),
    .batteryBackup(batteryBackup), .freqOutEnable(freqOutEnable), .alarmPulse(alarmPulse), .irq(irq));
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task tick(input logic [7:0] mn, input logic exp);
    @(posedge clk);
    timeMinutes <= mn; secondTick <= 1'b1;
    @(posedge clk);
    secondTick <= 1'b0;
    #1 `CHK(alarmPulse, exp)
  endtask
  task summarize;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK(q, 32'h0)
    end
    `CHK(freqOutEnable, 1'b1)
    apb(1'b0, 12'h02c, 32'h0);
    `CHK(e, 1'b1)
    @(posedge clk);
    `CHK(pslverr, 1'b0)
    $display("test reset done");
  endtask
  task t_modes;
    int pv [3] = '{3300, 2900, 2000};
    logic bk, bus;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `RBG_OFF_CTRL, 32'(m));
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        vdd <= pv[k]; bat <= 3000;
        repeat (3) @(posedge clk);
        bk = m[0] ? pv[k] <= 3000 : pv[k] <= 2200;
        bus = pv[k] > 2700 && (m[0] ? (m[1] ? pv[k] > 3000 : (!bk || 3000 > 2700)) : !bk);
        `CHK(batteryBackup, bk)
        `CHK(busEnable, bus)
        `CHK(eepromEnable, bus)
        `CHK(freqOutEnable, 1'b1)
      end
    end
    @(posedge clk);
    vdd <= 3300;
    apb(1'b0, `RBG_OFF_STATUS, 32'h0);
    `CHK(q[1], 1'b1)
    $display("test modes done");
  endtask
  task t_alarm;
    logic [7:0] v [6] = '{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00};
    for (int i = 0; i < 6; i++) apb(1'b1, 12'(4 * i), {24'h0, v[i]});
    apb(1'b0, `RBG_OFF_ALM_HR, 32'h0);
    `CHK(q, 32'h91)
    apb(1'b1, `RBG_OFF_MASK, 32'h1);
    apb(1'b1, `RBG_OFF_CTRL, 32'h8);
    tick(8'h29, 1'b0);
    tick(8'h30, 1'b1);
    `CHK(irq, 1'b1)
    tick(8'h30, 1'b0);
    apb(1'b0, `RBG_OFF_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    @(posedge clk);
    #1 `CHK(irq, 1'b0)
    apb(1'b1, `RBG_OFF_CTRL, 32'hc);
    tick(8'h30, 1'b1);
    tick(8'h30, 1'b1);
    apb(1'b1, `RBG_OFF_CTRL, 32'h0);
    tick(8'h30, 1'b0);
    $display("test alarm done");
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, secondTick, paddr, pwdata} = '0;
    {timeSeconds, timeHours, timeDate, timeMonth, timeWeekday} = {8'h59, 8'h11, 8'h01, 8'h01, 8'h05};
    timeMinutes = 8'h00; vdd = 3300; bat = 3000; err_total = 0; n_tests = 0; cyc = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_modes();
    t_alarm();
    summarize();
  end
endmodule
